// ---- cms_coproc_end.sv ----
/*
 Coprocessor end: a three-stage EX/CR/WB tracker that follows the core's
 sideband, cancelling, stalling and suspending in step with it.
 Assumes the core end on the same clk.
*/
`timescale 1ns/1ps
module cms_coproc_end (
    input wire logic clk,
    input wire logic rstn,
    input wire logic issue_valid,
    output logic ex_valid,
    output logic cr_valid,
    output logic wb_valid,
    output logic wb_commit,
    output logic cr_odd,
    cms_link_if.coproc link
);
    import cms_pkg::*;

    logic ex_odd;
    logic stall;
    logic suspend;
    logic cancel_cr;
    logic blf;

    assign stall = !link.pipe_stall_monitor_n;
    assign suspend = !link.suspend_ex_request_n;
    assign blf = !link.branch_likely_false_even_n;
    // Odd-only cancel hits only an odd instruction; otherwise all of CR
    assign cancel_cr = !link.pipe_cancel_check_n &&
        (link.cancel_odd_only_n || cr_odd);

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ex_valid <= 1'h0;
            ex_odd <= 1'h0;
            cr_valid <= 1'h0;
            cr_odd <= 1'h0;
            wb_valid <= 1'h0;
            wb_commit <= 1'h0;
        end else if (stall) begin
            wb_commit <= 1'h0;
        end else begin
            wb_valid <= cr_valid && !cancel_cr;
            wb_commit <= wb_valid;
            if (suspend) begin
                cr_valid <= 1'h0;
                if (!link.pipe_cancel_check_n || blf) begin
                    ex_valid <= 1'h0;
                end
            end else if (!link.pipe_cancel_check_n) begin
                // Flush younger work so nothing re-executes after the handler
                ex_valid <= 1'h0;
                cr_valid <= 1'h0;
            end else begin
                cr_valid <= ex_valid && !blf;
                cr_odd <= ex_odd;
                ex_valid <= issue_valid;
                ex_odd <= !link.coproc_odd_slot_n;
            end
        end
    end
endmodule : cms_coproc_end

// ---- cms_core_end.sv ----
/*
 Core end: turns core pipeline events and bus-unit requests into the
 registered monitor and sideband outputs, active-low apart from the clock monitor and the buses.
 Assumes user-side inputs are synchronous to clk.
*/
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module cms_core_end (
    input wire logic clk,
    input wire logic rstn,
    input wire logic branch_likely_even,
    input wire logic branch_likely_taken,
    input wire logic exception_raise,
    input wire logic exception_odd_only,
    input wire logic issue_odd_slot,
    input wire logic all_stages_stalled,
    input wire logic suspend_ex,
    input wire logic txn_req,
    input wire logic [31:0] txn_addr,
    input wire logic txn_write,
    input wire logic [63:0] txn_wdata,
    input wire logic txn_ifetch,
    input wire logic txn_burst,
    input wire logic txn_beat_done,
    output logic txn_accept,
    output logic txn_done,
    cms_link_if.core link
);
    import cms_pkg::*;

    cms_bus_state_t state;
    logic [1:0] beat_cnt;
    logic clk_phase;
    logic last_beat;

    //////////////////////////////////////////////////////////////////////////
    // Pipeline sideband, all registered so they move only on clk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.branch_likely_false_even_n <= RST_LOW_ACTIVE_IDLE;
            link.pipe_cancel_check_n <= RST_LOW_ACTIVE_IDLE;
            link.cancel_odd_only_n <= RST_LOW_ACTIVE_IDLE;
            link.coproc_odd_slot_n <= RST_LOW_ACTIVE_IDLE;
            link.pipe_stall_monitor_n <= RST_LOW_ACTIVE_IDLE;
            link.suspend_ex_request_n <= RST_LOW_ACTIVE_IDLE;
        end else begin
            link.branch_likely_false_even_n <= !(branch_likely_even && !branch_likely_taken);
            link.pipe_cancel_check_n <= !exception_raise;
            // Qualifier forced idle outside a cancel so it never looks meaningful
            link.cancel_odd_only_n <= !(exception_raise && exception_odd_only);
            link.coproc_odd_slot_n <= !issue_odd_slot;
            link.pipe_stall_monitor_n <= !all_stages_stalled;
            link.suspend_ex_request_n <= !suspend_ex;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus transaction sequencer
    assign last_beat = txn_beat_done && (!txn_burst || beat_cnt == BURST_BEATS);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= CMS_IDLE;
            beat_cnt <= 2'h0;
        end else begin
            case (state)
                CMS_IDLE: begin
                    if (txn_req) begin
                        state <= CMS_BEAT;
                    end
                    beat_cnt <= 2'h0;
                end
                CMS_BEAT: begin
                    if (txn_beat_done) begin
                        beat_cnt <= beat_cnt + 2'h1;
                    end
                    if (last_beat) begin
                        // Back-to-back start avoids an idle cycle
                        state <= txn_req ? CMS_BEAT : CMS_IDLE;
                        beat_cnt <= 2'h0;
                    end
                end
                default: begin
                    state <= CMS_IDLE;
                end
            endcase
        end
    end

    logic start_now;
    assign start_now = txn_req && (state == CMS_IDLE || (state == CMS_BEAT && last_beat));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.sys_addr_out_valid_n <= RST_LOW_ACTIVE_IDLE;
            link.sys_addr_out <= RST_ADDR;
            link.sys_bus_ready_n <= 1'h0;
            link.sys_txn_start_n <= RST_LOW_ACTIVE_IDLE;
            link.sys_data_out_valid_n <= RST_LOW_ACTIVE_IDLE;
            link.sys_data_out <= RST_DATA;
            link.sys_ifetch_monitor_n <= RST_LOW_ACTIVE_IDLE;
            link.sys_burst_first_n <= RST_LOW_ACTIVE_IDLE;
            txn_accept <= 1'h0;
            txn_done <= 1'h0;
        end else begin
            txn_accept <= start_now;
            txn_done <= state == CMS_BEAT && last_beat;
            link.sys_txn_start_n <= !start_now;
            if (start_now) begin
                link.sys_addr_out_valid_n <= 1'h0;
                link.sys_addr_out <= txn_addr;
                link.sys_bus_ready_n <= 1'h1;
                link.sys_data_out_valid_n <= !txn_write;
                link.sys_data_out <= txn_wdata;
                link.sys_ifetch_monitor_n <= !txn_ifetch;
                link.sys_burst_first_n <= !txn_burst;
            end else if (state == CMS_BEAT) begin
                if (txn_beat_done) begin
                    link.sys_burst_first_n <= 1'h1;
                end
                if (last_beat) begin
                    link.sys_addr_out_valid_n <= 1'h1;
                    link.sys_bus_ready_n <= 1'h0;
                    link.sys_data_out_valid_n <= 1'h1;
                    link.sys_ifetch_monitor_n <= 1'h1;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Clock monitor: registered half-rate copy, since a flop cannot pass clk itself
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_phase <= 1'h0;
        end else begin
            clk_phase <= !clk_phase;
        end
    end
    assign link.internal_clock_monitor = clk_phase;
    // Write-back is untouched by the cancel output; nothing here drains it
endmodule : cms_core_end

// ---- cms_link_if.sv ----
/*
 Interface that joins the core end and the coprocessor end.
 Assumes both ends are clocked by the same clk.
*/
`timescale 1ns/1ps
interface cms_link_if;
    logic branch_likely_false_even_n;
    logic pipe_cancel_check_n;
    logic cancel_odd_only_n;
    logic coproc_odd_slot_n;
    logic pipe_stall_monitor_n;
    logic suspend_ex_request_n;
    logic sys_addr_out_valid_n;
    logic [31:0] sys_addr_out;
    logic sys_bus_ready_n;
    logic sys_txn_start_n;
    logic sys_data_out_valid_n;
    logic [63:0] sys_data_out;
    logic sys_ifetch_monitor_n;
    logic sys_burst_first_n;
    logic internal_clock_monitor;
    modport core (
        output branch_likely_false_even_n, pipe_cancel_check_n, cancel_odd_only_n,
        coproc_odd_slot_n, pipe_stall_monitor_n, suspend_ex_request_n,
        sys_addr_out_valid_n, sys_addr_out, sys_bus_ready_n, sys_txn_start_n,
        sys_data_out_valid_n, sys_data_out, sys_ifetch_monitor_n,
        sys_burst_first_n, internal_clock_monitor
    );
    modport coproc (
        input branch_likely_false_even_n, pipe_cancel_check_n, cancel_odd_only_n,
        coproc_odd_slot_n, pipe_stall_monitor_n, suspend_ex_request_n,
        sys_addr_out_valid_n, sys_addr_out, sys_bus_ready_n, sys_txn_start_n,
        sys_data_out_valid_n, sys_data_out, sys_ifetch_monitor_n,
        sys_burst_first_n, internal_clock_monitor
    );
endinterface : cms_link_if

// ---- cms_link_properties.sv ----
/*
 Checker for the core-to-coprocessor sideband link.
 Assumes one clock and plain inputs taken from the link interface.
*/
`timescale 1ns/1ps
module cms_link_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pipe_cancel_check_n,
    input wire logic cancel_odd_only_n,
    input wire logic sys_addr_out_valid_n,
    input wire logic [31:0] sys_addr_out,
    input wire logic sys_bus_ready_n,
    input wire logic sys_txn_start_n,
    input wire logic sys_data_out_valid_n,
    input wire logic sys_ifetch_monitor_n,
    input wire logic sys_burst_first_n,
    input wire logic internal_clock_monitor
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_opened;
        !sys_addr_out_valid_n && sys_bus_ready_n;
    endsequence
    property p_odd_qual; !cancel_odd_only_n |-> !pipe_cancel_check_n; endproperty
    property p_start; !sys_txn_start_n |-> s_opened; endproperty
    property p_free; !sys_bus_ready_n |-> sys_addr_out_valid_n; endproperty
    // Ready goes high only as a new transaction opens
    property p_busy; $rose(sys_bus_ready_n) |-> !sys_txn_start_n; endproperty
    property p_write; !sys_data_out_valid_n |-> !sys_addr_out_valid_n; endproperty
    property p_fetch; !sys_ifetch_monitor_n |-> !sys_addr_out_valid_n; endproperty
    property p_burst; $fell(sys_burst_first_n) |-> s_opened; endproperty
    property p_addr_hold;
        !sys_addr_out_valid_n && sys_txn_start_n |-> $stable(sys_addr_out);
    endproperty
    // Guarded so the reset-time value is never compared
    property p_clk_mon;
        $past(rstn) |-> internal_clock_monitor != $past(internal_clock_monitor);
    endproperty
    a_odd_qual: assert property (p_odd_qual)
        else $error("odd qualifier without cancel");
    a_start: assert property (p_start)
        else $error("start strobe outside a transaction");
    a_free: assert property (p_free)
        else $error("bus free while address valid");
    a_busy: assert property (p_busy)
        else $error("ready raised without a start");
    a_write: assert property (p_write)
        else $error("data valid outside a transaction");
    a_fetch: assert property (p_fetch)
        else $error("fetch monitor outside a transaction");
    a_burst: assert property (p_burst)
        else $error("burst flag outside a transaction");
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved mid transaction");
    a_clk_mon: assert property (p_clk_mon)
        else $error("clock monitor stuck");
endmodule : cms_link_properties

// ---- cms_pkg.sv ----
/*
 Shared constants and types for the core monitor and coprocessor sideband link.
 Assumes one clock domain shared by the core end and the coprocessor end.
*/
package cms_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam logic [1:0] BURST_BEATS = 2'h3;
    localparam logic RST_LOW_ACTIVE_IDLE = 1'h1;
    localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0;
    localparam logic [DATA_W-1:0] RST_DATA = 64'h0;
    typedef enum logic [1:0] {CMS_IDLE, CMS_ADDR, CMS_BEAT} cms_bus_state_t;
    typedef enum logic [1:0] {CMS_STG_EMPTY, CMS_STG_HELD, CMS_STG_RUN} cms_stage_t;
endpackage : cms_pkg

// ---- test_core_monitor_coproc_sideband.sv ----
/*
 Self-checking bench: core end and coprocessor end joined by the link.
 Assumes one 50 MHz clock and inputs driven by non-blocking assignment.
*/
`timescale 1ns/1ps
module test_core_monitor_coproc_sideband;
    logic clk = 0, rstn = 0, ble = 0, blt = 0, exc = 0, exo = 0, odd = 0;
    logic stl = 0, sus = 0, iss = 0, req = 0, wr = 0, ifx = 0, bst = 0, bd = 0;
    logic [31:0] ad = '0;
    logic [63:0] wd = '0;
    logic acc, wbc;
    int n_fail = 0, n_tests = 0, cyc = 0;
    cms_link_if link ();
    cms_core_end cms_core_end_i (.clk(clk), .rstn(rstn), .branch_likely_even(ble),
        .branch_likely_taken(blt), .exception_raise(exc), .exception_odd_only(exo),
        .issue_odd_slot(odd), .all_stages_stalled(stl), .suspend_ex(sus), .txn_req(req),
        .txn_addr(ad), .txn_write(wr), .txn_wdata(wd), .txn_ifetch(ifx), .txn_burst(bst),
        .txn_beat_done(bd), .txn_accept(acc), .txn_done(), .link(link));
    cms_coproc_end cms_coproc_end_i (.clk(clk), .rstn(rstn), .issue_valid(iss),
        .ex_valid(), .cr_valid(), .wb_valid(), .wb_commit(wbc), .cr_odd(), .link(link));
    cms_link_properties cms_link_properties_i (.clk(clk), .rstn(rstn),
        .pipe_cancel_check_n(link.pipe_cancel_check_n),
        .cancel_odd_only_n(link.cancel_odd_only_n),
        .sys_addr_out_valid_n(link.sys_addr_out_valid_n), .sys_addr_out(link.sys_addr_out),
        .sys_bus_ready_n(link.sys_bus_ready_n), .sys_txn_start_n(link.sys_txn_start_n),
        .sys_data_out_valid_n(link.sys_data_out_valid_n),
        .sys_ifetch_monitor_n(link.sys_ifetch_monitor_n),
        .sys_burst_first_n(link.sys_burst_first_n),
        .internal_clock_monitor(link.internal_clock_monitor));
    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic t_sideband;
        for (int i = 0; i < 128; i++) begin
            @(posedge clk);
            {ble, blt, exc, exo, odd, stl, sus} <= 7'(i);
            @(posedge clk);
            @(negedge clk);
            chk(link.branch_likely_false_even_n, !(ble && !blt));
            chk(link.pipe_cancel_check_n, !exc);
            chk(link.cancel_odd_only_n, !(exc && exo));
            chk(link.coproc_odd_slot_n, !odd);
            chk(link.pipe_stall_monitor_n, !stl);
            chk(link.suspend_ex_request_n, !sus);
        end
        @(posedge clk);
        {ble, blt, exc, exo, odd, stl, sus} <= 7'h0;
    endtask : t_sideband
    // One instruction issued alone or beside an exception or a false branch-likely
    task automatic t_pipe(input logic e, input logic b, input logic c);
        logic seen;
        seen = 0;
        @(posedge clk);
        iss <= 1; exc <= e; ble <= b;
        @(posedge clk);
        iss <= 0; exc <= 0; ble <= 0;
        repeat (6) begin
            @(negedge clk);
            seen |= wbc;
        end
        chk(seen, c);
    endtask : t_pipe
    task automatic t_txn(input logic [31:0] a, input logic w, input logic f, input logic b,
        input logic [63:0] d);
        int n;
        n = b ? 4 : 1;
        @(posedge clk);
        req <= 1; ad <= a; wr <= w; ifx <= f; bst <= b; wd <= d;
        for (int k = 0; k < 50 && !acc; k++) @(negedge clk);
        chk(acc, 1'h1);
        chk({link.sys_txn_start_n, link.sys_addr_out_valid_n, link.sys_bus_ready_n}, 3'h1);
        chk(link.sys_addr_out, a);
        chk(link.sys_data_out_valid_n, !w);
        if (w) chk(link.sys_data_out, d);
        chk(link.sys_ifetch_monitor_n, !f);
        chk(link.sys_burst_first_n, !b);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            req <= 0; bd <= 1;
            @(posedge clk);
            bd <= 0;
            @(negedge clk);
            chk(link.sys_burst_first_n, 1'h1);
            chk(link.sys_txn_start_n, 1'h1);
            chk({link.sys_addr_out_valid_n, link.sys_bus_ready_n}, k < n - 1 ? 2'h1 : 2'h2);
        end
    endtask : t_txn
    //////////////////////////////////////////////////////////////////////////////
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        @(negedge clk);
        chk({link.sys_bus_ready_n, link.sys_txn_start_n}, 2'h1);
        t_sideband;
        t_pipe(1'h0, 1'h0, 1'h1);
        t_pipe(1'h1, 1'h0, 1'h0);
        t_pipe(1'h0, 1'h1, 1'h0);
        t_txn(32'h1000_0040, 1'h0, 1'h1, 1'h0, 64'h0);
        t_txn(32'h2000_0008, 1'h1, 1'h0, 1'h0, 64'hA5A5_0F0F_1234_5678);
        t_txn(32'h0000_0100, 1'h0, 1'h0, 1'h1, 64'h0);
        t_txn(32'hFFFF_FFE0, 1'h1, 1'h0, 1'h1, 64'h8000_0000_0000_0001);
        test_done;
    end
endmodule : test_core_monitor_coproc_sideband
